// *** rtl/nvmw_ctrl.sv ***
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "nvmw_cfg.svh"
module nvmw_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic blk_rst,
  input wire logic prog_protect,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic fl_req,
  output logic [1:0] fl_op,
  output logic fl_cfg,
  output logic [14:0] fl_addr,
  output logic [13:0] fl_wdata,
  input wire logic fl_ack,
  input wire logic [13:0] fl_rdata
);
  // ***********************************************
  // state
  // ***********************************************
  typedef struct packed {
    logic awready; // bus handshakes
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_have; // write address held
    logic [7:0] aw_addr;
    logic w_have; // write data held
    logic [7:0] w_data;
    logic w_lane0;
    logic [7:0] dat_lo; // word value
    logic [5:0] dat_hi;
    logic [7:0] adr_lo; // word address
    logic [6:0] adr_hi;
    logic cfg_sel; // control bits
    logic latch_only;
    logic erase_sel;
    logic err;
    logic write_enable;
    logic wr;
    logic rd;
    logic [1:0] unlock; // keys seen so far
    nvmw_pkg::nvmw_state_t st;
    nvmw_pkg::nvmw_op_t op;
    logic single; // one word, no row loop
    logic [4:0] widx; // word within row
    logic fl_req;
    logic fl_cfg;
    logic [14:0] fl_addr;
    logic [13:0] fl_wdata;
    logic lt_ld; // latch load pulse
    logic [4:0] lt_idx;
    logic [13:0] lt_data;
    logic lt_blank;
  } nvmw_ctrl_state_t;

  nvmw_ctrl_state_t s_reg; // registered state
  nvmw_ctrl_state_t s_next; // next state
  logic [13:0] lt_rd; // latch word at widx
  logic bus_wr; // register write this cycle
  logic ctl_wr; // control register written
  logic wr_go; // accepted write start
  logic rd_go; // accepted read start
  logic latch_case; // latch-only load selected
  logic wprot; // target is write-protected
  logic rd_bad; // config read outside regions
  logic unlock_bad; // unlock sequence broken
  logic busy; // self-write under way
  logic in_uid; // region hits
  logic in_id;
  logic in_cw;
  logic in_ee;
  logic [15:0] tgt; // select plus address
  logic [7:0] wd; // byte being written
  logic keep_err;

  // ***********************************************
  // write latch row
  // ***********************************************
  nvmw_latch u_latch (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ld(s_reg.lt_ld),
    .ld_idx(s_reg.lt_idx),
    .ld_data(s_reg.lt_data),
    .blank(s_reg.lt_blank),
    .rd_idx(s_reg.widx),
    .rd_data(lt_rd)
  );

  // ***********************************************
  // next state
  // ***********************************************
  always_comb begin
    s_next = s_reg;
    s_next.fl_req = 1'b0;
    s_next.lt_ld = 1'b0;
    s_next.lt_blank = 1'b0;
    bus_wr = 1'b0;
    ctl_wr = 1'b0;
    wr_go = 1'b0;
    rd_go = 1'b0;
    unlock_bad = 1'b0;
    keep_err = 1'b0;
    wd = s_reg.w_data;
    busy = (s_reg.st != nvmw_pkg::nvmw_st_idle) && s_reg.wr;
    // sequencer towards the array
    unique case (s_reg.st)
      nvmw_pkg::nvmw_st_idle: begin
        s_next.st = nvmw_pkg::nvmw_st_idle;
      end
      nvmw_pkg::nvmw_st_issue: begin
        s_next.fl_req = 1'b1;
        if (!s_reg.single && s_reg.op == nvmw_pkg::nvmw_op_write) begin
          s_next.fl_addr[4:0] = s_reg.widx;
        end
        // eeprom takes the low byte only, upper bits forced to zero
        s_next.fl_wdata = s_reg.single ? {6'h00, s_reg.dat_lo} : lt_rd;
        s_next.st = nvmw_pkg::nvmw_st_wait;
      end
      nvmw_pkg::nvmw_st_wait: begin
        if (fl_ack) begin
          if (s_reg.op == nvmw_pkg::nvmw_op_read) begin
            s_next.dat_lo = fl_rdata[7:0];
            s_next.dat_hi = fl_rdata[13:8];
          end
          if (s_reg.op == nvmw_pkg::nvmw_op_write && !s_reg.single
              && s_reg.widx != `NVMW_ROW_LAST) begin
            s_next.widx = s_reg.widx + 5'h01;
            s_next.st = nvmw_pkg::nvmw_st_issue;
          end else begin
            s_next.st = nvmw_pkg::nvmw_st_finish;
          end
        end
      end
      nvmw_pkg::nvmw_st_finish: begin
        s_next.wr = 1'b0;
        s_next.rd = 1'b0;
        // row program and row erase both leave the latches blank
        s_next.lt_blank = (s_reg.op != nvmw_pkg::nvmw_op_read) && !s_reg.single;
        s_next.st = nvmw_pkg::nvmw_st_idle;
      end
    endcase
    // write address and data, in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_lane0 = s_axi_wstrb[0];
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    // both halves present: commit and answer next edge
    if (s_next.aw_have && s_next.w_have && !s_reg.bvalid) begin
      bus_wr = s_next.w_lane0;
      wd = s_next.w_data;
      s_next.bvalid = 1'b1;
      s_next.bresp = (s_next.aw_addr[1:0] == 2'h0 && s_next.aw_addr <= `NVMW_OFF_UNLOCK)
        ? `NVMW_RESP_OKAY : `NVMW_RESP_SLVERR;
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
    end
    // register writes; a broken unlock is caught on any other write
    if (bus_wr) begin
      if (s_reg.unlock == 2'h1 && !(s_next.aw_addr == `NVMW_OFF_UNLOCK
          && wd == `NVMW_KEY_SECOND)) begin
        unlock_bad = 1'b1;
      end
      if (s_reg.unlock == 2'h2 && !(s_next.aw_addr == `NVMW_OFF_CONTROL
          && wd[`NVMW_BIT_WRITE])) begin
        unlock_bad = 1'b1;
      end
      case (s_next.aw_addr)
        `NVMW_OFF_DATA_LOW: s_next.dat_lo = wd;
        `NVMW_OFF_DATA_HIGH: s_next.dat_hi = wd[5:0];
        `NVMW_OFF_ADDR_LOW: s_next.adr_lo = wd;
        `NVMW_OFF_ADDR_HIGH: s_next.adr_hi = wd[6:0];
        `NVMW_OFF_CONTROL: begin
          ctl_wr = 1'b1;
          s_next.cfg_sel = wd[`NVMW_BIT_CFG];
          s_next.latch_only = wd[`NVMW_BIT_LATCH];
          s_next.erase_sel = wd[`NVMW_BIT_ERASE];
          s_next.write_enable = wd[`NVMW_BIT_WRITE_ENABLE];
          s_next.err = wd[`NVMW_BIT_ERR];
          // start needs both keys, enable and an idle sequencer
          wr_go = wd[`NVMW_BIT_WRITE] && wd[`NVMW_BIT_WRITE_ENABLE]
            && s_reg.unlock == 2'h2 && s_reg.st == nvmw_pkg::nvmw_st_idle;
          rd_go = wd[`NVMW_BIT_READ] && !wr_go
            && s_reg.st == nvmw_pkg::nvmw_st_idle;
          s_next.unlock = 2'h0;
        end
        `NVMW_OFF_UNLOCK: begin
          if (s_reg.unlock == 2'h0 && wd == `NVMW_KEY_FIRST) begin
            s_next.unlock = 2'h1;
          end else if (s_reg.unlock == 2'h1 && wd == `NVMW_KEY_SECOND) begin
            s_next.unlock = 2'h2;
          end else begin
            s_next.unlock = 2'h0;
          end
        end
        default: begin
          s_next.unlock = 2'h0; // unmapped write still breaks the keys
        end
      endcase
      // a broken sequence must not leave a key behind for a later start
      if (unlock_bad) begin
        s_next.unlock = 2'h0;
      end
    end
    // region decode on the freshly written selection
    tgt = {s_next.cfg_sel, s_next.adr_hi, s_next.adr_lo};
    in_uid = tgt >= `NVMW_UID_LO && tgt <= `NVMW_UID_HI;
    in_id = tgt >= `NVMW_ID_LO && tgt <= `NVMW_ID_HI;
    in_cw = tgt >= `NVMW_CW_LO && tgt <= `NVMW_CW_HI;
    in_ee = tgt >= `NVMW_EE_LO && tgt <= `NVMW_EE_HI;
    latch_case = s_next.latch_only && !s_next.erase_sel;
    // only user ID and eeprom take writes in config space
    wprot = s_next.cfg_sel ? !(in_uid || in_ee) : prog_protect;
    rd_bad = s_next.cfg_sel && !(in_uid || in_id || in_cw || in_ee);
    if (wr_go) begin
      if (latch_case) begin
        // protection not checked, no array request
        s_next.lt_ld = 1'b1;
        s_next.lt_idx = s_next.adr_lo[4:0];
        s_next.lt_data = {s_next.dat_hi, s_next.dat_lo};
      end else if (wprot) begin
        s_next.wr = 1'b0;
      end else begin
        s_next.wr = 1'b1;
        s_next.st = nvmw_pkg::nvmw_st_issue;
        s_next.op = s_next.erase_sel ? nvmw_pkg::nvmw_op_erase
          : nvmw_pkg::nvmw_op_write;
        s_next.single = s_next.cfg_sel && in_ee && !s_next.erase_sel;
        s_next.widx = 5'h00;
        s_next.fl_cfg = s_next.cfg_sel;
        s_next.fl_addr = {s_next.adr_hi, s_next.adr_lo};
        if (!s_next.single) begin
          s_next.fl_addr[4:0] = 5'h00;
        end
      end
    end
    if (rd_go) begin
      if (rd_bad) begin
        s_next.dat_lo = `NVMW_RST_BYTE;
        s_next.dat_hi = 6'h00;
      end else begin
        s_next.rd = 1'b1;
        s_next.st = nvmw_pkg::nvmw_st_issue;
        s_next.op = nvmw_pkg::nvmw_op_read;
        s_next.single = 1'b1;
        s_next.fl_cfg = s_next.cfg_sel;
        s_next.fl_addr = {s_next.adr_hi, s_next.adr_lo};
      end
    end
    // hardware sets after the software write, so only a block reset in the same cycle loses a set
    if (unlock_bad || (wr_go && !latch_case && wprot)) begin
      s_next.err = 1'b1;
    end
    // register read
    if (s_axi_rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = `NVMW_RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `NVMW_OFF_DATA_LOW: s_next.rdata[7:0] = s_reg.dat_lo;
        `NVMW_OFF_DATA_HIGH: s_next.rdata[7:0] = {2'h0, s_reg.dat_hi};
        `NVMW_OFF_ADDR_LOW: s_next.rdata[7:0] = s_reg.adr_lo;
        `NVMW_OFF_ADDR_HIGH: s_next.rdata[7:0] = {`NVMW_ADDR_HIGH_PAD, s_reg.adr_hi};
        `NVMW_OFF_CONTROL: s_next.rdata[7:0] = {1'b0, s_reg.cfg_sel, s_reg.latch_only,
          s_reg.erase_sel, s_reg.err, s_reg.write_enable, s_reg.wr, s_reg.rd};
        `NVMW_OFF_UNLOCK: s_next.rdata[7:0] = 8'h00; // keys never read back
        default: s_next.rresp = `NVMW_RESP_SLVERR;
      endcase
    end
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready = !s_next.w_have && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
    // block reset: every controller register but a set error flag drops, the write latches keep their words; a cut-off self-write sets that flag
    if (blk_rst) begin
      keep_err = s_reg.err || busy;
      s_next = '0;
      s_next.err = keep_err;
    end
  end

  // ***********************************************
  // registers
  // ***********************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign fl_req = s_reg.fl_req;
  assign fl_op = s_reg.op;
  assign fl_cfg = s_reg.fl_cfg;
  assign fl_addr = s_reg.fl_addr;
  assign fl_wdata = s_reg.fl_wdata;

  // ***********************************************
  // checks
  // ***********************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_uid_write_ok: assert property (
    wr_go && !latch_case && s_next.cfg_sel && in_uid && !blk_rst |=> s_reg.wr ##1 fl_req)
    else $error("user id write not started");
  a_id_write_refused: assert property (
    wr_go && !latch_case && (in_id || in_cw) && s_next.cfg_sel && !blk_rst
    |=> s_reg.err && !s_reg.wr && !fl_req)
    else $error("id or config word write not refused");
  a_prot_sets_err: assert property (
    wr_go && !latch_case && wprot |=> s_reg.err)
    else $error("protected start did not flag error");
  a_prot_no_array: assert property (
    wr_go && !latch_case && wprot |=> (!fl_req && !s_reg.wr) [*3])
    else $error("protected start touched the array");
  a_reset_busy_err: assert property (
    blk_rst && busy |=> s_reg.err)
    else $error("reset during self-write lost error");
  a_unlock_break: assert property (
    unlock_bad |=> s_reg.err && s_reg.unlock == 2'h0)
    else $error("broken unlock not flagged");
  a_err_sticky: assert property (
    s_reg.err && !ctl_wr |=> s_reg.err)
    else $error("error flag cleared by hardware");
  a_latch_no_mem: assert property (
    wr_go && latch_case |=> (!fl_req && s_reg.st == nvmw_pkg::nvmw_st_idle) [*4])
    else $error("latch load reached the array");
  a_ee_high_ignored: assert property (
    fl_req && s_reg.single && fl_op == nvmw_pkg::nvmw_op_write |-> fl_wdata[13:8] == 6'h00)
    else $error("eeprom write used high data");
  a_bad_read_zero: assert property (
    rd_go && rd_bad && !blk_rst |=> s_reg.dat_lo == 8'h00 && s_reg.dat_hi == 6'h00 && !fl_req)
    else $error("unpermitted read did not clear data");
  a_start_held: assert property (
    s_reg.st != nvmw_pkg::nvmw_st_idle && s_reg.op != nvmw_pkg::nvmw_op_read
    |-> s_reg.wr)
    else $error("write start dropped mid operation");
endmodule

// *** include/nvmw_cfg.svh ***
`ifndef NVMW_CFG_SVH
`define NVMW_CFG_SVH
// ***********************************************
// register byte offsets
// ***********************************************
`define NVMW_OFF_DATA_LOW 8'h00
`define NVMW_OFF_DATA_HIGH 8'h04
`define NVMW_OFF_ADDR_LOW 8'h08
`define NVMW_OFF_ADDR_HIGH 8'h0C
`define NVMW_OFF_CONTROL 8'h10
`define NVMW_OFF_UNLOCK 8'h14
// ***********************************************
// control register bit positions
// ***********************************************
`define NVMW_BIT_READ 0
`define NVMW_BIT_WRITE 1
`define NVMW_BIT_WRITE_ENABLE 2
`define NVMW_BIT_ERR 3
`define NVMW_BIT_ERASE 4
`define NVMW_BIT_LATCH 5
`define NVMW_BIT_CFG 6
// ***********************************************
// reset values, keys and region bounds
// ***********************************************
`define NVMW_RST_BYTE 8'h00
`define NVMW_ADDR_HIGH_PAD 1'h1
`define NVMW_KEY_FIRST 8'h55
`define NVMW_KEY_SECOND 8'hAA
`define NVMW_UID_LO 16'h8000
`define NVMW_UID_HI 16'h8003
`define NVMW_ID_LO 16'h8005
`define NVMW_ID_HI 16'h8006
`define NVMW_CW_LO 16'h8007
`define NVMW_CW_HI 16'h800A
`define NVMW_EE_LO 16'hF000
`define NVMW_EE_HI 16'hF0FF
`define NVMW_BLANK_WORD 14'h3FFF
`define NVMW_ROW_LAST 5'h1F
`define NVMW_RESP_OKAY 2'h0
`define NVMW_RESP_SLVERR 2'h2
`endif

// *** include/nvmw_pkg.sv ***
package nvmw_pkg;
  // sequencer states, gray along idle-issue-wait-finish
  typedef enum logic [1:0] {
    nvmw_st_idle = 2'h0,
    nvmw_st_issue = 2'h1,
    nvmw_st_wait = 2'h3,
    nvmw_st_finish = 2'h2
  } nvmw_state_t;
  // memory-side operation codes
  typedef enum logic [1:0] {
    nvmw_op_read = 2'h0,
    nvmw_op_write = 2'h1,
    nvmw_op_erase = 2'h2
  } nvmw_op_t;
endpackage

// *** rtl/nvmw_latch.sv ***
`timescale 1ns/100ps
`include "nvmw_cfg.svh"
module nvmw_latch (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ld,
  input wire logic [4:0] ld_idx,
  input wire logic [13:0] ld_data,
  input wire logic blank,
  input wire logic [4:0] rd_idx,
  output logic [13:0] rd_data
);
  // one row of write latches
  typedef struct packed {
    logic [31:0][13:0] word;
  } nvmw_latch_state_t;

  nvmw_latch_state_t s_reg; // registered latches
  nvmw_latch_state_t s_next; // next latches

  // blank wins over load: a finished row leaves nothing stale
  always_comb begin
    s_next = s_reg;
    if (blank) begin
      s_next.word = {32{`NVMW_BLANK_WORD}};
    end else if (ld) begin
      s_next.word[ld_idx] = ld_data;
    end
  end

  // latches come up blank
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= {32{`NVMW_BLANK_WORD}};
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.word[rd_idx];
endmodule

// *** verif/nvmw_tb.sv ***
`timescale 1ns/100ps
`include "nvmw_cfg.svh"
module testbench;
  // ************************************
  // stimulus and observed signals
  // ************************************
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic blk_rst = 1'b0;
  logic prog_protect = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic fl_req, fl_cfg;
  logic [1:0] fl_op;
  logic [14:0] fl_addr;
  logic [13:0] fl_wdata;
  logic fl_ack = 1'b0;
  logic [13:0] fl_rdata = 14'h2A5C; // fixed word returned by the array stand-in
  int err_total = 0;
  int check_count = 0;

  // clock: half period 12.5 ns
  always #12.5 clk_sys = ~clk_sys;

  nvmw_ctrl uut (
    .clk_sys(clk_sys), .arst_n(arst_n), .blk_rst(blk_rst), .prog_protect(prog_protect),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .fl_req(fl_req), .fl_op(fl_op),
    .fl_cfg(fl_cfg), .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_ack(fl_ack),
    .fl_rdata(fl_rdata)
  );

  // ************************************
  // array stand-in
  // ************************************
  logic [1:0] pend = 2'h0;
  int req_cnt = 0;
  logic [1:0] last_op;
  logic last_cfg;
  logic [14:0] last_addr;
  logic [13:0] last_wdata;
  logic [13:0] row_word [32];
  // acks three edges after each request, records what was asked
  always @(posedge clk_sys) begin
    pend <= {pend[0], fl_req === 1'b1};
    fl_ack <= pend[1];
    if (fl_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
      last_op <= fl_op;
      last_cfg <= fl_cfg;
      last_addr <= fl_addr;
      last_wdata <= fl_wdata;
      row_word[fl_addr[4:0]] <= fl_wdata;
    end
  end

  // ************************************
  // shared tasks
  // ************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  // one write; both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er = `NVMW_RESP_OKAY);
    logic [1:0] r;
    r = 2'h3;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        break;
      end
    end
    s_axi_bready <= 1'b0;
    check("write response", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    input logic [1:0] er = `NVMW_RESP_OKAY);
    logic [1:0] r;
    r = 2'h3;
    d = 32'hFFFFFFFF;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        break;
      end
    end
    s_axi_rready <= 1'b0;
    check("read response", {30'h0, r}, {30'h0, er});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    logic [31:0] d;
    rd(a, d);
    check(nm, d & m, e);
  endtask

  // both keys then the control write
  task automatic go(input logic [7:0] ctl);
    wr(`NVMW_OFF_UNLOCK, `NVMW_KEY_FIRST);
    wr(`NVMW_OFF_UNLOCK, `NVMW_KEY_SECOND);
    wr(`NVMW_OFF_CONTROL, ctl);
  endtask

  // polls control until the masked start bits fall, bounded
  task automatic wait_clr(input logic [31:0] m);
    logic [31:0] d;
    d = m;
    for (int i = 0; i < 400 && (d & m) != 0; i++) rd(`NVMW_OFF_CONTROL, d);
    check("start bits", d & m, 32'h0);
  endtask

  // ************************************
  // scenarios
  // ************************************
  task automatic t_regs();
    logic [31:0] d;
    rchk(`NVMW_OFF_DATA_LOW, 32'hFFFFFFFF, 32'h00, "data low reset");
    rchk(`NVMW_OFF_DATA_HIGH, 32'hFFFFFFFF, 32'h00, "data high reset");
    rchk(`NVMW_OFF_ADDR_LOW, 32'hFFFFFFFF, 32'h00, "address low reset");
    rchk(`NVMW_OFF_ADDR_HIGH, 32'hFFFFFFFF, 32'h80, "address high reset");
    wr(`NVMW_OFF_DATA_HIGH, 8'hFF);
    rchk(`NVMW_OFF_DATA_HIGH, 32'hFFFFFFFF, 32'h3F, "data high");
    wr(`NVMW_OFF_DATA_LOW, 8'hA5);
    rchk(`NVMW_OFF_DATA_LOW, 32'hFFFFFFFF, 32'hA5, "data low");
    // low byte lane off: the write is answered but changes nothing
    s_axi_wstrb <= 4'hE;
    wr(`NVMW_OFF_DATA_LOW, 8'h00);
    s_axi_wstrb <= 4'hF;
    rchk(`NVMW_OFF_DATA_LOW, 32'hFFFFFFFF, 32'hA5, "masked write");
    wr(`NVMW_OFF_ADDR_LOW, 8'hC3);
    rchk(`NVMW_OFF_ADDR_LOW, 32'hFFFFFFFF, 32'hC3, "address low");
    wr(`NVMW_OFF_ADDR_HIGH, 8'h7F);
    rchk(`NVMW_OFF_ADDR_HIGH, 32'hFFFFFFFF, 32'hFF, "address high");
    wr(8'h18, 8'h01, `NVMW_RESP_SLVERR);
    rd(8'h18, d, `NVMW_RESP_SLVERR);
    $display("test registers done");
  endtask

  task automatic t_row();
    int n;
    wr(`NVMW_OFF_ADDR_HIGH, 8'h00);
    wr(`NVMW_OFF_ADDR_LOW, 8'h23);
    wr(`NVMW_OFF_DATA_HIGH, 8'h12);
    wr(`NVMW_OFF_DATA_LOW, 8'h34);
    n = req_cnt;
    go(8'h26);
    rchk(`NVMW_OFF_CONTROL, 32'h02, 32'h00, "start after load");
    check("requests after load", req_cnt - n, 0);
    go(8'h06);
    rchk(`NVMW_OFF_CONTROL, 32'h02, 32'h02, "start while busy");
    wait_clr(32'h02);
    check("row requests", req_cnt - n, 32);
    check("row op", {30'h0, last_op}, nvmw_pkg::nvmw_op_write);
    check("loaded word", row_word[3], 14'h1234);
    check("unloaded word", row_word[0], `NVMW_BLANK_WORD);
    go(8'h06);
    wait_clr(32'h02);
    check("word after blanking", row_word[3], `NVMW_BLANK_WORD);
    $display("test row program done");
  endtask

  task automatic t_protect();
    int n;
    n = req_cnt;
    prog_protect <= 1'b1;
    go(8'h06);
    rchk(`NVMW_OFF_CONTROL, 32'h0A, 32'h08, "protected program");
    wr(`NVMW_OFF_CONTROL, 8'h00);
    rchk(`NVMW_OFF_CONTROL, 32'h08, 32'h00, "flag cleared");
    go(8'h16);
    rchk(`NVMW_OFF_CONTROL, 32'h0A, 32'h08, "protected erase");
    check("protected requests", req_cnt - n, 0);
    go(8'h2E);
    rchk(`NVMW_OFF_CONTROL, 32'h08, 32'h08, "flag kept");
    wr(`NVMW_OFF_CONTROL, 8'h00);
    wr(`NVMW_OFF_CONTROL, 8'h08);
    rchk(`NVMW_OFF_CONTROL, 32'h08, 32'h08, "flag set by write");
    wr(`NVMW_OFF_CONTROL, 8'h00);
    prog_protect <= 1'b0;
    wr(`NVMW_OFF_UNLOCK, `NVMW_KEY_FIRST);
    wr(`NVMW_OFF_ADDR_LOW, 8'h00);
    rchk(`NVMW_OFF_CONTROL, 32'h08, 32'h08, "broken unlock");
    wr(`NVMW_OFF_CONTROL, 8'h00);
    $display("test protection done");
  endtask

  task automatic t_erase();
    int n;
    n = req_cnt;
    wr(`NVMW_OFF_ADDR_HIGH, 8'h01);
    wr(`NVMW_OFF_ADDR_LOW, 8'h27);
    go(8'h36);
    wait_clr(32'h02);
    check("erase requests", req_cnt - n, 1);
    check("erase op", {30'h0, last_op}, nvmw_pkg::nvmw_op_erase);
    check("erase row", {17'h0, last_addr}, 32'h0120);
    $display("test erase done");
  endtask

  task automatic t_config();
    int n;
    wr(`NVMW_OFF_DATA_LOW, 8'h11);
    wr(`NVMW_OFF_DATA_HIGH, 8'h11);
    wr(`NVMW_OFF_ADDR_HIGH, 8'h00);
    wr(`NVMW_OFF_ADDR_LOW, 8'h04);
    n = req_cnt;
    wr(`NVMW_OFF_CONTROL, 8'h41);
    wait_clr(32'h01);
    rchk(`NVMW_OFF_DATA_LOW, 32'hFF, 32'h00, "gap read low");
    rchk(`NVMW_OFF_DATA_HIGH, 32'hFF, 32'h00, "gap read high");
    check("gap requests", req_cnt - n, 0);
    wr(`NVMW_OFF_ADDR_LOW, 8'h05);
    wr(`NVMW_OFF_CONTROL, 8'h41);
    wait_clr(32'h01);
    check("id read kind", {29'h0, last_cfg, last_op}, 32'h4);
    rchk(`NVMW_OFF_DATA_LOW, 32'hFF, {24'h0, fl_rdata[7:0]}, "id read low");
    rchk(`NVMW_OFF_DATA_HIGH, 32'hFF, {26'h0, fl_rdata[13:8]}, "id read high");
    wr(`NVMW_OFF_ADDR_LOW, 8'h07);
    go(8'h46);
    rchk(`NVMW_OFF_CONTROL, 32'h0A, 32'h08, "config word write");
    wr(`NVMW_OFF_CONTROL, 8'h40);
    wr(`NVMW_OFF_ADDR_HIGH, 8'h70);
    wr(`NVMW_OFF_ADDR_LOW, 8'h10);
    wr(`NVMW_OFF_DATA_HIGH, 8'h3F);
    wr(`NVMW_OFF_DATA_LOW, 8'h5A);
    go(8'h46);
    wait_clr(32'h02);
    check("eeprom word", last_wdata, 14'h005A);
    check("eeprom address", {17'h0, last_addr}, 32'h7010);
    rchk(`NVMW_OFF_CONTROL, 32'h08, 32'h00, "eeprom error");
    // user id row program in config space: full row, no error
    wr(`NVMW_OFF_ADDR_HIGH, 8'h00);
    wr(`NVMW_OFF_ADDR_LOW, 8'h01);
    n = req_cnt;
    go(8'h46);
    wait_clr(32'h02);
    check("user id requests", req_cnt - n, 32);
    check("user id space", {31'h0, last_cfg}, 32'h1);
    rchk(`NVMW_OFF_CONTROL, 32'h08, 32'h00, "user id error");
    $display("test config space done");
  endtask

  task automatic t_reset_write();
    wr(`NVMW_OFF_CONTROL, 8'h00);
    go(8'h06);
    repeat (6) @(posedge clk_sys);
    blk_rst <= 1'b1;
    @(posedge clk_sys);
    blk_rst <= 1'b0;
    rchk(`NVMW_OFF_CONTROL, 32'h0A, 32'h08, "reset in write");
    $display("test reset in write done");
  endtask

  // ************************************
  // run control
  // ************************************
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence: reset for two edges, then scenarios
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    t_regs();
    t_row();
    t_protect();
    t_erase();
    t_config();
    t_reset_write();
    end_sim();
  end

  // watchdog: far beyond the thousand or so cycles the run needs
  initial begin
    #500000;
    err_total++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
